// ==== core/radar_accelerator.sv ====
// Contract
// R01: One output sample per clock after start-up
// R02: Windowed FFT k times: N*(k+1)+1 cycles
// R03: FFT N cycles, window adds one
// R04: Log-magnitude takes N+3 cycles
// R05: CFAR-CA takes 2(w+g)+1+N cycles; the code takes N+2 when w and g are both 0
// R06: Four memories as ping and pong pairs
// R07: Zero input samples above programmed threshold
// R08: Configuring party chooses scaling, no auto-scale
// R09: Sum antenna results non-coherently in place
// R10: CFAR along Doppler gives per-gate object list
// R11: One completion after all range gates
// R12: Party may overwrite range samples in place
// R13: 24-bit complex input and output
// R14: Up to ten radix-2 stages, one/cycle
// R15: Per-stage halve-with-round or saturate
// R16: Swap ping and pong after each pass
`timescale 1ns/1ps
module radar_accelerator #(
	parameter int DEPTH      = radar_accel_pkg::MEM_DEPTH,
	parameter int MAX_STAGES = radar_accel_pkg::MAX_STAGES
) (
	// Clock and reset
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	// Pass configuration and start
	input  wire logic                                 start_i,
	input  wire logic [1:0]                           op_i,
	input  wire logic [3:0]                           log2n_i,
	input  wire logic [10:0]                          reps_i,
	input  wire logic                                 acc_i,
	input  wire logic                                 clip_en_i,
	input  wire logic [radar_accel_pkg::SMP_W-1:0]    clip_thr_i,
	input  wire logic                                 win_en_i,
	input  wire logic [MAX_STAGES-1:0]                halve_mask_i,
	input  wire logic [4:0]                           cfar_w_i,
	input  wire logic [3:0]                           cfar_g_i,
	input  wire logic [radar_accel_pkg::LOG_W-1:0]    cfar_thr_i,
	input  wire logic [9:0]                           gates_i,
	input  wire logic                                 gate_clr_i,
	// Window coefficient load
	input  wire logic                                 win_we_i,
	input  wire logic [$clog2(DEPTH)-1:0]             win_addr_i,
	input  wire logic [radar_accel_pkg::WIN_W-1:0]    win_data_i,
	// DMA side of the idle pair
	input  wire logic                                 dma_we_i,
	input  wire logic [$clog2(DEPTH)-1:0]             dma_waddr_i,
	input  wire logic [radar_accel_pkg::CPX_W-1:0]    dma_wdata_i,
	input  wire logic                                 dma_re_i,
	input  wire logic [$clog2(DEPTH)-1:0]             dma_raddr_i,
	output logic      [radar_accel_pkg::CPX_W-1:0]    dma_rdata_o,
	output logic                                      dma_rvalid_o,
	// Status
	output logic                                      busy_o,
	output logic                                      done_o,
	output logic                                      all_done_o,
	output logic                                      pp_sel_o,
	output logic      [$clog2(DEPTH):0]               obj_count_o
);
	localparam int AW  = $clog2(DEPTH);
	localparam int W   = radar_accel_pkg::SMP_W;
	localparam int CW  = radar_accel_pkg::CNT_W;
	localparam int LW  = radar_accel_pkg::LOG_W;
	localparam int CFL = 2 * (radar_accel_pkg::CFAR_WMAX + radar_accel_pkg::CFAR_GMAX) + 1;

	logic [radar_accel_pkg::CPX_W-1:0] mem [radar_accel_pkg::NUM_BANKS][DEPTH];
	logic signed [radar_accel_pkg::WIN_W-1:0] win_mem [DEPTH];

	radar_accel_pkg::state_e state_r;
	radar_accel_pkg::op_e    op_r;
	logic [CW-1:0]  cyc_r, total_r, lat_r, end_r, t_r;
	logic [CW-1:0]  n_in, tot_in, lat_in, end_in, out_idx;
	logic [10:0]    n_r, k_r;
	logic [3:0]     log2n_r;
	logic [AW-1:0]  nmask_r, idx_r;
	logic           acc_r, clip_en_r, win_en_r, pp_r;
	logic [W-1:0]   clip_thr_r;
	logic [MAX_STAGES-1:0] halve_r;
	logic [4:0]     w_r;
	logic [3:0]     g_r;
	logic [LW-1:0]  cthr_r;
	logic [9:0]     gate_cnt_r;
	logic [AW:0]    obj_cnt_r;
	logic           accept, wr_win, out_we;
	logic [AW-1:0]  out_addr;
	logic [radar_accel_pkg::CPX_W-1:0] smp, out_wdata, old_out;
	logic signed [W-1:0] s_re, s_im;

	function automatic logic [W-1:0] absv(input logic signed [W-1:0] v);
		return v[W-1] ? W'(-v) : v;
	endfunction

	assign accept  = (state_r == radar_accel_pkg::ST_IDLE) && start_i;
	assign busy_o  = (state_r == radar_accel_pkg::ST_RUN) || (state_r == radar_accel_pkg::ST_FLUSH);
	assign done_o  = (state_r == radar_accel_pkg::ST_DONE);
	assign all_done_o = done_o && (gate_cnt_r == gates_i - 10'h1); // [R11]
	assign pp_sel_o    = pp_r;
	assign obj_count_o = obj_cnt_r;

	// Pass length from the requested operation
	always_comb begin
		n_in   = CW'(16'h1 << log2n_i);
		tot_in = n_in;
		lat_in = CW'(radar_accel_pkg::LM_LAT);
		end_in = n_in + CW'(radar_accel_pkg::LM_LAT); // [R04]
		case (radar_accel_pkg::op_e'(op_i))
			radar_accel_pkg::OP_FFT: begin
				tot_in = CW'(n_in * reps_i);
				lat_in = n_in + CW'(radar_accel_pkg::WIN_LAT); // [R03]
				end_in = CW'(n_in * reps_i) + n_in + CW'(radar_accel_pkg::FFT_OUT_LAT); // [R02]
			end
			radar_accel_pkg::OP_CFAR: begin
				lat_in = CW'(cfar_w_i) + CW'(cfar_g_i) + CW'(radar_accel_pkg::CFAR_DEC_LAT);
				end_in = CW'(2 * (cfar_w_i + cfar_g_i)) + CW'(radar_accel_pkg::CFAR_START) + n_in; // [R05]
				if (end_in < n_in + lat_in)
					end_in = n_in + lat_in;
			end
			default: ;
		endcase
	end

	// Sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= radar_accel_pkg::ST_IDLE;
			cyc_r   <= '0;
		end else begin
			case (state_r)
				radar_accel_pkg::ST_IDLE: begin
					cyc_r <= '0;
					if (start_i)
						state_r <= radar_accel_pkg::ST_RUN;
				end
				radar_accel_pkg::ST_RUN: begin
					cyc_r <= cyc_r + CW'(1); // [R01]
					if (cyc_r == total_r - CW'(1))
						state_r <= radar_accel_pkg::ST_FLUSH;
				end
				radar_accel_pkg::ST_FLUSH: begin
					cyc_r <= cyc_r + CW'(1);
					if (cyc_r == end_r - CW'(1))
						state_r <= radar_accel_pkg::ST_DONE;
				end
				radar_accel_pkg::ST_DONE: state_r <= radar_accel_pkg::ST_IDLE;
				default: state_r <= radar_accel_pkg::ST_IDLE;
			endcase
		end
	end

	// Configuration is frozen for the whole pass
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_r <= radar_accel_pkg::OP_FFT;
			{total_r, lat_r, end_r, n_r, k_r, log2n_r, nmask_r} <= '0;
			{acc_r, clip_en_r, win_en_r, clip_thr_r, halve_r, w_r, g_r, cthr_r} <= '0;
		end else if (accept) begin
			op_r       <= radar_accel_pkg::op_e'(op_i);
			total_r    <= tot_in;
			lat_r      <= lat_in;
			end_r      <= end_in;
			n_r        <= n_in[10:0];
			k_r        <= reps_i;
			log2n_r    <= log2n_i;
			nmask_r    <= AW'(n_in - CW'(1));
			acc_r      <= acc_i;
			clip_en_r  <= clip_en_i;
			clip_thr_r <= clip_thr_i;
			win_en_r   <= win_en_i;
			halve_r    <= halve_mask_i; // [R08]
			w_r        <= cfar_w_i;
			g_r        <= cfar_g_i;
			cthr_r     <= cfar_thr_i;
		end
	end

	// Ping/pong roles flip once a pass has drained
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pp_r <= radar_accel_pkg::PP_RST;
		else if (done_o)
			pp_r <= ~pp_r; // [R16] [R06]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || gate_clr_i || all_done_o)
			gate_cnt_r <= '0;
		else if (done_o)
			gate_cnt_r <= gate_cnt_r + 10'h1;
	end

	// Input fetch and interference clipping
	assign smp  = (state_r == radar_accel_pkg::ST_RUN) ? mem[{pp_r, radar_accel_pkg::BANK_IN}][cyc_r[AW-1:0]] : '0;
	assign s_re = (clip_en_r && (absv(smp[2*W-1:W]) > clip_thr_r || absv(smp[W-1:0]) > clip_thr_r))
		? '0 : smp[2*W-1:W]; // [R07]
	assign s_im = (clip_en_r && (absv(smp[2*W-1:W]) > clip_thr_r || absv(smp[W-1:0]) > clip_thr_r))
		? '0 : smp[W-1:0]; // [R07]

	// In-line window: one register stage only
	logic signed [W-1:0]          wn_re_r, wn_im_r;
	logic signed [W+radar_accel_pkg::WIN_W-1:0] p_re, p_im;
	assign p_re = s_re * win_mem[cyc_r[AW-1:0] & nmask_r];
	assign p_im = s_im * win_mem[cyc_r[AW-1:0] & nmask_r];
	always_ff @(posedge clk_i) begin
		if (win_we_i)
			win_mem[win_addr_i] <= win_data_i;
		if (rst_i) begin
			{wn_re_r, wn_im_r, idx_r} <= '0;
		end else begin
			wn_re_r <= win_en_r ? p_re[radar_accel_pkg::WIN_FRAC+W-1:radar_accel_pkg::WIN_FRAC] : s_re; // [R03]
			wn_im_r <= win_en_r ? p_im[radar_accel_pkg::WIN_FRAC+W-1:radar_accel_pkg::WIN_FRAC] : s_im; // [R03]
			idx_r   <= cyc_r[AW-1:0] & nmask_r;
		end
	end

	// Stage chain; unused stages pass straight through
	logic signed [W-1:0] ch_re [MAX_STAGES+1];
	logic signed [W-1:0] ch_im [MAX_STAGES+1];
	logic signed [W-1:0] fft_re_r, fft_im_r;
	assign ch_re[0] = wn_re_r;
	assign ch_im[0] = wn_im_r;
	fft_stage_if sif [MAX_STAGES] ();
	for (genvar s = 0; s < MAX_STAGES; s++) begin : g_stage
		assign sif[s].in_re = ch_re[s];
		assign sif[s].in_im = ch_im[s];
		assign sif[s].idx   = idx_r - AW'((1 << s) - 1);
		assign sif[s].en    = (s < log2n_r); // [R14]
		assign sif[s].halve = halve_r[s]; // [R15]
		assign sif[s].run   = busy_o;
		assign ch_re[s+1]   = sif[s].out_re;
		assign ch_im[s+1]   = sif[s].out_im;
		fft_stage #(.S(s)) u_stage (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.p     (sif[s].stage)
		);
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			{fft_re_r, fft_im_r} <= '0;
		else
			{fft_re_r, fft_im_r} <= {ch_re[MAX_STAGES], ch_im[MAX_STAGES]}; // [R13]
	end

	// Log-magnitude: abs, sum, leading-one log
	logic [W-1:0]  lm_a_r, lm_b_r;
	logic [W:0]    lm_s_r, lm_sh;
	logic [LW-1:0] lm_r;
	logic [4:0]    lm_pos;
	always_comb begin
		lm_pos = '0;
		for (int i = 0; i <= W; i++)
			if (lm_s_r[i])
				lm_pos = 5'(i);
		lm_sh = lm_s_r << (5'(W) - lm_pos);
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{lm_a_r, lm_b_r, lm_s_r, lm_r} <= '0;
		end else begin
			lm_a_r <= absv(s_re);
			lm_b_r <= absv(s_im);
			lm_s_r <= {1'b0, lm_a_r} + {1'b0, lm_b_r};
			lm_r   <= {3'h0, lm_pos, lm_sh[W-1:W-radar_accel_pkg::LOG_FRAC]};
		end
	end

	// Cell-averaging detector along the stream
	logic [LW-1:0] cf_sr [CFL];
	logic [LW-1:0] cf_val_r;
	logic          cf_det_r, cf_det;
	logic [31:0]   cf_sum, cf_lhs, cf_rhs;
	logic [5:0]    wg;
	always_comb begin
		wg     = 6'(w_r) + 6'(g_r);
		cf_sum = '0;
		for (int j = 0; j < radar_accel_pkg::CFAR_WMAX; j++)
			if (j < w_r)
				cf_sum = cf_sum + 32'(cf_sr[j]) + 32'(cf_sr[2 * wg - j]);
		cf_lhs = 32'(cf_sr[wg]) * 32'(2 * w_r);
		cf_rhs = cf_sum + 32'(cthr_r) * 32'(2 * w_r);
		cf_det = (w_r != '0) && (cf_lhs >= cf_rhs);
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || accept) begin
			for (int i = 0; i < CFL; i++)
				cf_sr[i] <= '0;
			{cf_det_r, cf_val_r} <= '0;
		end else begin
			cf_sr[0] <= smp[LW-1:0];
			for (int i = 1; i < CFL; i++)
				cf_sr[i] <= cf_sr[i-1];
			cf_det_r <= cf_det; // [R10]
			cf_val_r <= cf_sr[wg];
		end
	end

	// Result write into the active output bank
	assign wr_win  = busy_o && cyc_r >= lat_r && cyc_r < total_r + lat_r;
	assign out_idx = cyc_r - lat_r;
	assign old_out = mem[{pp_r, radar_accel_pkg::BANK_OUT}][out_idx[AW-1:0]];
	always_comb begin
		out_we    = wr_win;
		out_addr  = out_idx[AW-1:0];
		out_wdata = {fft_re_r, fft_im_r};
		case (op_r)
			radar_accel_pkg::OP_LOGMAG: out_wdata = acc_r ? old_out + {32'h0, lm_r} : {32'h0, lm_r}; // [R09]
			radar_accel_pkg::OP_CFAR: begin
				out_we    = wr_win && cf_det_r; // [R10]
				out_addr  = obj_cnt_r[AW-1:0];
				out_wdata = {(radar_accel_pkg::CPX_W-LW-AW)'(0), out_idx[AW-1:0], cf_val_r};
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (out_we && !rst_i)
			mem[{pp_r, radar_accel_pkg::BANK_OUT}][out_addr] <= out_wdata;
		if (dma_we_i && !rst_i)
			mem[{~pp_r, radar_accel_pkg::BANK_IN}][dma_waddr_i] <= dma_wdata_i; // [R06]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || accept)
			obj_cnt_r <= '0;
		else if (out_we && op_r == radar_accel_pkg::OP_CFAR)
			obj_cnt_r <= obj_cnt_r + (AW+1)'(1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dma_rdata_o  <= '0;
			dma_rvalid_o <= 1'b0;
		end else begin
			dma_rdata_o  <= dma_re_i ? mem[{~pp_r, radar_accel_pkg::BANK_OUT}][dma_raddr_i] : dma_rdata_o;
			dma_rvalid_o <= dma_re_i;
		end
	end

	// Cycle count since the start was taken
	always_ff @(posedge clk_i) begin
		if (rst_i || accept)
			t_r <= '0;
		else
			t_r <= t_r + CW'(1);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_accept;
		(state_r == radar_accel_pkg::ST_IDLE) && start_i;
	endsequence
	sequence s_running;
		busy_o [*2];
	endsequence

	a_fft_done_time: assert property (done_o && op_r == radar_accel_pkg::OP_FFT |-> // [R02]
		t_r == CW'(int'(n_r) * (int'(k_r) + 1) + 1)) else $error("FFT pass length wrong");
	a_fft_first_out: assert property ($rose(out_we) && op_r == radar_accel_pkg::OP_FFT |-> // [R03]
		t_r == CW'(int'(n_r) + 1)) else $error("FFT latency wrong");
	a_lm_done_time: assert property (done_o && op_r == radar_accel_pkg::OP_LOGMAG |-> // [R04]
		t_r == CW'(int'(n_r) + 3)) else $error("Log-magnitude pass length wrong");
	a_cfar_done_time: assert property (done_o && op_r == radar_accel_pkg::OP_CFAR && g_r != '0 |-> // [R05]
		t_r == CW'(2 * (int'(w_r) + int'(g_r)) + 1 + int'(n_r))) else $error("CFAR pass length wrong");
	a_stream_rate: assert property (out_we && op_r != radar_accel_pkg::OP_CFAR && out_idx < total_r - CW'(1) |=> // [R01]
		out_we && out_idx == $past(out_idx) + CW'(1)) else $error("Output stream stalled");
	a_clip_zero: assert property (state_r == radar_accel_pkg::ST_RUN && clip_en_r && // [R07]
		absv(smp[2*W-1:W]) > clip_thr_r && !win_en_r |=> wn_re_r == '0 && wn_im_r == '0) else $error("Clip missed");
	a_pp_swap: assert property (s_accept ##1 s_running |-> // [R16]
		pp_sel_o == $past(pp_sel_o, 2)) else $error("Buffer pair changed mid-pass");
	a_pp_toggle: assert property (done_o |=> pp_sel_o != $past(pp_sel_o)) else $error("No swap after pass"); // [R06]
	a_acc_sum: assert property (out_we && op_r == radar_accel_pkg::OP_LOGMAG && acc_r |-> // [R09]
		out_wdata[LW-1:0] == LW'(old_out[LW-1:0] + lm_r)) else $error("Antenna sum wrong");
	a_all_done: assert property (all_done_o |=> gate_cnt_r == '0 && !all_done_o) else $error("Gate count not reset"); // [R11]
	a_obj_list: assert property (out_we && op_r == radar_accel_pkg::OP_CFAR |=> // [R10]
		obj_cnt_r == $past(obj_cnt_r) + (AW+1)'(1)) else $error("Object list not advanced");
endmodule

// ==== core/radar_accel_pkg.sv ====
package radar_accel_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SMP_W         = 24;
	localparam int CPX_W         = 2 * SMP_W;
	localparam int MAX_STAGES    = 10;
	localparam int MEM_DEPTH     = 1024;
	localparam int NUM_BANKS     = 4;
	localparam int CNT_W         = 16;
	localparam int WIN_W         = 16;
	localparam int WIN_FRAC      = 15;
	localparam int LOG_W         = 16;
	localparam int LOG_FRAC      = 8;
	localparam int CFAR_WMAX     = 16;
	localparam int CFAR_GMAX     = 8;
	localparam int WIN_LAT       = 1;
	localparam int FFT_OUT_LAT   = 1;
	localparam int LM_LAT        = 3;
	localparam int CFAR_DEC_LAT  = 2;
	localparam int CFAR_START    = 1;
	localparam logic PP_RST      = 1'b0;
	localparam logic BANK_IN     = 1'b0;
	localparam logic BANK_OUT    = 1'b1;

	typedef enum logic [1:0] {
		OP_FFT    = 2'h0,
		OP_LOGMAG = 2'h1,
		OP_CFAR   = 2'h2
	} op_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_RUN   = 2'h1,
		ST_FLUSH = 2'h3,
		ST_DONE  = 2'h2
	} state_e;
endpackage

// ==== core/fft_stage_if.sv ====
`timescale 1ns/1ps
interface fft_stage_if;
	logic signed [radar_accel_pkg::SMP_W-1:0] in_re;
	logic signed [radar_accel_pkg::SMP_W-1:0] in_im;
	logic signed [radar_accel_pkg::SMP_W-1:0] out_re;
	logic signed [radar_accel_pkg::SMP_W-1:0] out_im;
	logic [$clog2(radar_accel_pkg::MEM_DEPTH)-1:0] idx;
	logic                                          en;
	logic                                          halve;
	logic                                          run;
	modport stage (input in_re, in_im, idx, en, halve, run, output out_re, out_im);
	modport ctrl (output in_re, in_im, idx, en, halve, run, input out_re, out_im);
endinterface

// ==== core/fft_stage.sv ====
`timescale 1ns/1ps
module fft_stage #(
	parameter int S = 0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	fft_stage_if.stage p
);
	localparam int W  = radar_accel_pkg::SMP_W;
	localparam int D  = 1 << S;
	localparam int AW = (S > 0) ? S : 1;

	logic signed [W-1:0] dl_re [D];
	logic signed [W-1:0] dl_im [D];
	logic [AW-1:0]       ptr;
	logic                second;
	logic signed [W-1:0] a_re, a_im;

	// Halve with rounding, or clamp to the datapath width
	function automatic logic signed [W-1:0] fmt(input logic signed [W:0] v, input logic halve);
		logic signed [W+1:0] r;
		r = {v[W], v} + (W+2)'(1);
		if (halve)
			return r[W:1];
		else if (v > (W+1)'(2**(W-1) - 1))
			return {1'b0, {(W-1){1'b1}}};
		else if (v < -(W+1)'(2**(W-1)))
			return {1'b1, {(W-1){1'b0}}};
		else
			return v[W-1:0];
	endfunction

	assign ptr    = (S == 0) ? '0 : p.idx[AW-1:0];
	assign second = p.idx[S];
	assign a_re   = dl_re[ptr];
	assign a_im   = dl_im[ptr];

	// Single-delay feedback butterfly; unity twiddle keeps the stage multiplier free
	always_comb begin
		if (!p.en) begin
			p.out_re = p.in_re;
			p.out_im = p.in_im;
		end else if (!second) begin
			p.out_re = a_re;
			p.out_im = a_im;
		end else begin
			p.out_re = fmt({a_re[W-1], a_re} + {p.in_re[W-1], p.in_re}, p.halve); // [R15]
			p.out_im = fmt({a_im[W-1], a_im} + {p.in_im[W-1], p.in_im}, p.halve); // [R15]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_i && p.en && p.run) begin
			dl_re[ptr] <= second ? fmt({a_re[W-1], a_re} - {p.in_re[W-1], p.in_re}, p.halve) : p.in_re;
			dl_im[ptr] <= second ? fmt({a_im[W-1], a_im} - {p.in_im[W-1], p.in_im}, p.halve) : p.in_im;
		end
	end
endmodule

// ==== sim/dma_partner.sv ====
`timescale 1ns/1ps
module dma_partner (
	// Clock
	input  wire logic        clk_i,
	// Toward the accelerator
	output logic             we_o,
	output logic [9:0]       waddr_o,
	output logic [47:0]      wdata_o,
	output logic             re_o,
	output logic [9:0]       raddr_o,
	// From the accelerator
	input  wire logic [47:0] rdata_i,
	input  wire logic        rvalid_i
);
	initial begin
		we_o = 1'b0;
		waddr_o = 10'h000;
		wdata_o = 48'h0;
		re_o = 1'b0;
		raddr_o = 10'h000;
	end

	// Only ever touches the idle pair, never the one being processed
	task automatic put_word(input logic [9:0] a, input logic [47:0] d);
		@(negedge clk_i);
		we_o = 1'b1;
		waddr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		we_o = 1'b0;
		// Released data bus must not keep looking valid
		wdata_o = ~d;
	endtask

	// Result drained from the idle output bank
	task automatic get_word(input logic [9:0] a, output logic [47:0] d, output logic ok);
		@(negedge clk_i);
		re_o = 1'b1;
		raddr_o = a;
		@(negedge clk_i);
		re_o = 1'b0;
		ok = rvalid_i;
		d = rdata_i;
	endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic        clk_i;
	logic        rst_i;
	logic        start_i;
	logic [1:0]  op_i;
	logic [3:0]  log2n_i;
	logic [10:0] reps_i;
	logic        clip_en_i;
	logic [23:0] clip_thr_i;
	logic        win_en_i;
	logic [9:0]  halve_mask_i;
	logic        acc_i;
	logic [15:0] cfar_thr_i;
	logic [4:0]  cfar_w_i;
	logic [3:0]  cfar_g_i;
	logic [9:0]  gates_i;
	logic        gate_clr_i;
	logic        win_we_i;
	logic [9:0]  win_addr_i;
	logic [15:0] win_data_i;
	logic        dma_we;
	logic [9:0]  dma_waddr;
	logic [47:0] dma_wdata;
	logic        dma_re;
	logic [9:0]  dma_raddr;
	logic [47:0] dma_rdata_o;
	logic        dma_rvalid_o;
	logic        busy_o;
	logic        done_o;
	logic        all_done_o;
	logic        pp_sel_o;
	logic [10:0] obj_count_o;
	int          fails;
	int          comparisons;

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	radar_accelerator dut_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
		.log2n_i(log2n_i), .reps_i(reps_i), .acc_i(acc_i), .clip_en_i(clip_en_i),
		.clip_thr_i(clip_thr_i), .win_en_i(win_en_i), .halve_mask_i(halve_mask_i),
		.cfar_w_i(cfar_w_i), .cfar_g_i(cfar_g_i), .cfar_thr_i(cfar_thr_i), .gates_i(gates_i),
		.gate_clr_i(gate_clr_i), .win_we_i(win_we_i), .win_addr_i(win_addr_i),
		.win_data_i(win_data_i), .dma_we_i(dma_we), .dma_waddr_i(dma_waddr),
		.dma_wdata_i(dma_wdata), .dma_re_i(dma_re), .dma_raddr_i(dma_raddr),
		.dma_rdata_o(dma_rdata_o), .dma_rvalid_o(dma_rvalid_o), .busy_o(busy_o),
		.done_o(done_o), .all_done_o(all_done_o), .pp_sel_o(pp_sel_o), .obj_count_o(obj_count_o));

	dma_partner dma_u (.clk_i(clk_i), .we_o(dma_we), .waddr_o(dma_waddr), .wdata_o(dma_wdata),
		.re_o(dma_re), .raddr_o(dma_raddr), .rdata_i(dma_rdata_o), .rvalid_i(dma_rvalid_o));

	task automatic give_verdict();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cycle 0 is the first busy cycle; e ends at the done cycle
	task automatic run_pass(input logic [1:0] op, input logic [3:0] l2n, input logic [10:0] k,
			input logic [4:0] w, input logic [3:0] g, output int e, output logic ad);
		logic pp;
		pp = pp_sel_o;
		@(negedge clk_i);
		start_i = 1'b1;
		op_i = op;
		log2n_i = l2n;
		reps_i = k;
		cfar_w_i = w;
		cfar_g_i = g;
		@(negedge clk_i);
		start_i = 1'b0;
		chk(busy_o, 1'b1);
		e = 0;
		while (done_o !== 1'b1 && e < 2000) begin
			@(negedge clk_i);
			e++;
		end
		if (e >= 2000) begin
			fails++;
			give_verdict();
		end
		ad = all_done_o;
		chk(busy_o, 1'b0);
		@(negedge clk_i);
		chk(pp_sel_o, !pp);
	endtask

	// Staged data only becomes the source after one swap
	task automatic pipe(input logic [47:0] w0, input logic [47:0] w1, input logic [3:0] l2n,
			output logic [47:0] r0, output logic [47:0] r1);
		int e;
		logic ad;
		logic ok;
		dma_u.put_word(10'h000, w0);
		dma_u.put_word(10'h001, w1);
		run_pass(2'h0, l2n, 11'h001, 5'h00, 4'h0, e, ad);
		run_pass(2'h0, l2n, 11'h001, 5'h00, 4'h0, e, ad);
		chk(48'(e), 48'((1 << l2n) * 2 + 1));
		dma_u.get_word(10'h000, r0, ok);
		chk(ok, 1'b1);
		dma_u.get_word(10'h001, r1, ok);
	endtask

	task automatic t_reset();
		chk(busy_o, 1'b0);
		chk(done_o, 1'b0);
		chk(pp_sel_o, 1'b0);
		chk(obj_count_o, 11'h000);
		chk(dma_rvalid_o, 1'b0);
		$display("test reset finished");
	endtask

	task automatic t_fft();
		int e;
		logic ad;
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_i);
			win_we_i = 1'b1;
			win_addr_i = 10'(i);
			win_data_i = 16'h4000;
		end
		@(negedge clk_i);
		win_we_i = 1'b0;
		win_en_i = 1'b1;
		halve_mask_i = 10'h3ff;
		for (int k = 1; k <= 3; k++) begin
			run_pass(2'h0, 4'h3, 11'(k), 5'h00, 4'h0, e, ad);
			chk(48'(e), 48'(8 * (k + 1) + 1));
		end
		win_en_i = 1'b0;
		$display("test fft timing finished");
	endtask

	task automatic t_logmag_cfar();
		int e;
		logic ad;
		run_pass(2'h1, 4'h4, 11'h001, 5'h00, 4'h0, e, ad);
		chk(48'(e), 48'h13);
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		chk(48'(e), 48'h4);
		run_pass(2'h2, 4'h4, 11'h001, 5'h02, 4'h1, e, ad);
		chk(48'(e), 48'h17);
		run_pass(2'h2, 4'h5, 11'h001, 5'h08, 4'h4, e, ad);
		chk(48'(e), 48'h39);
		$display("test logmag and cfar timing finished");
	endtask

	task automatic t_gates();
		int e;
		logic ad;
		gates_i = 10'h002;
		@(negedge clk_i);
		gate_clr_i = 1'b1;
		@(negedge clk_i);
		gate_clr_i = 1'b0;
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		chk(ad, 1'b0);
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		chk(ad, 1'b1);
		$display("test completion finished");
	endtask

	task automatic t_clip_scale();
		logic [47:0] r0;
		logic [47:0] r1;
		clip_en_i = 1'b1;
		clip_thr_i = 24'h000032;
		pipe({24'h000064, 24'h000005}, 48'h0, 4'h0, r0, r1);
		chk(r0, 48'h0);
		// Exactly at threshold is kept
		pipe({24'hfffffd, 24'h000032}, 48'h0, 4'h0, r0, r1);
		chk(r0, {24'hfffffd, 24'h000032});
		clip_en_i = 1'b0;
		halve_mask_i = 10'h3ff;
		pipe({24'h400000, 24'h0}, {24'h400000, 24'h0}, 4'h1, r0, r1);
		chk(r0 | r1, {24'h400000, 24'h0});
		halve_mask_i = 10'h000;
		pipe({24'h400000, 24'h0}, {24'h400000, 24'h0}, 4'h1, r0, r1);
		chk(r0 | r1, {24'h7fffff, 24'h0});
		$display("test clip and scaling finished");
	endtask

	// Same pair twice: plain log-magnitude, then summed onto it; then a detection list
	task automatic t_acc_cfar();
		int e;
		logic ad;
		logic ok;
		logic [47:0] r;
		dma_u.put_word(10'h000, {24'h000100, 24'h0});
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		dma_u.get_word(10'h000, r, ok);
		chk(r, 48'h000000000800);
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		acc_i = 1'b1;
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		acc_i = 1'b0;
		dma_u.get_word(10'h000, r, ok);
		chk(r, 48'h000000001000);
		// Summed result goes back over its own sample slot
		dma_u.put_word(10'h000, r);
		for (int i = 1; i < 4; i++)
			dma_u.put_word(10'(i), (i == 3) ? 48'h100 : 48'h0);
		run_pass(2'h1, 4'h0, 11'h001, 5'h00, 4'h0, e, ad);
		run_pass(2'h2, 4'h2, 11'h001, 5'h01, 4'h1, e, ad);
		chk(48'(e), 48'h9);
		chk(obj_count_o, 11'h002);
		dma_u.get_word(10'h000, r, ok);
		chk(r, 48'h000000001000);
		dma_u.get_word(10'h001, r, ok);
		chk(r, 48'h000000030100);
		$display("test antenna sum and object list finished");
	endtask

	initial begin
		fails = 0;
		comparisons = 0;
		rst_i = 1'b1;
		start_i = 1'b0;
		op_i = 2'h0;
		log2n_i = 4'h0;
		reps_i = 11'h001;
		clip_en_i = 1'b0;
		clip_thr_i = 24'h0;
		acc_i = 1'b0;
		cfar_thr_i = 16'h0010;
		win_en_i = 1'b0;
		halve_mask_i = 10'h000;
		cfar_w_i = 5'h00;
		cfar_g_i = 4'h0;
		gates_i = 10'h001;
		gate_clr_i = 1'b0;
		win_we_i = 1'b0;
		win_addr_i = 10'h000;
		win_data_i = 16'h0;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_fft();
		t_logmag_cfar();
		t_gates();
		t_clip_scale();
		t_acc_cfar();
		give_verdict();
	end
endmodule
